// file: rtl/rtcw_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module rtcw_top
  import rtcw_pkg::*;
(
  input  wire logic        aclk,              // kernel clock, 250 MHz
  input  wire logic        aresetn,           // sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,      // write address
  input  wire logic        s_axi_awvalid,     // write address valid
  output logic             s_axi_awready,     // write address ready
  input  wire logic [31:0] s_axi_wdata,       // write data
  input  wire logic [3:0]  s_axi_wstrb,       // write byte enables
  input  wire logic        s_axi_wvalid,      // write data valid
  output logic             s_axi_wready,      // write data ready
  output logic [1:0]       s_axi_bresp,       // write response
  output logic             s_axi_bvalid,      // write response valid
  input  wire logic        s_axi_bready,      // write response ready
  input  wire logic [7:0]  s_axi_araddr,      // read address
  input  wire logic        s_axi_arvalid,     // read address valid
  output logic             s_axi_arready,     // read address ready
  output logic [31:0]      s_axi_rdata,       // read data
  output logic [1:0]       s_axi_rresp,       // read response
  output logic             s_axi_rvalid,      // read data valid
  input  wire logic        s_axi_rready,      // read data ready
  output logic             calib_output_pin,  // calibration output
  output logic             wakeup_event       // one-cycle pulse per expiry
);

  // ==========================================================
  // helper functions
  function automatic logic rtcw_reg_hit(input logic [7:0] addr);
    case (addr)
      RTCW_OFF_CTRL_ONE, RTCW_OFF_CTRL_TWO, RTCW_OFF_PRESCALER,
      RTCW_OFF_RELOAD, RTCW_OFF_STATUS, RTCW_OFF_COUNTER: rtcw_reg_hit = 1'b1;
      default: rtcw_reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rtcw_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    rtcw_merge = res;
  endfunction

  // ==========================================================
  // declarations
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic        aw_take, w_take, ar_take, wr_fire;
  logic        aw_held_next, w_held_next, bvalid_next, rvalid_next;
  logic [2:0]  wakeup_clock_select;
  logic        calib_output_select;
  logic [2:0]  source_clock_divider;
  logic        compact_variant;
  logic        wakeup_timer_enable;
  logic [6:0]  async_prescaler_value;
  logic [14:0] sync_prescaler_value;
  logic [15:0] wakeup_reload_value;
  logic [RTCW_WAF_DELAY-1:0] waf_pipe_reg;
  logic        wakeup_write_allowed_flag;
  logic        wakeup_flag_reg;
  logic [31:0] ctrl_one_rd, ctrl_two_rd, presc_rd, reload_rd, status_rd, count_rd;
  logic [31:0] rd_value;
  logic [RTCW_SRC_W-1:0]   src_cnt_reg;
  logic [RTCW_SRC_W-1:0]   src_mask;
  logic        src_tick;
  logic [RTCW_ASYNC_W-1:0] async_cnt;
  logic        async_tick;
  logic [RTCW_SYNC_W-1:0]  sync_cnt;
  logic        calendar_second_tick;
  logic [RTCW_CALIB_W-1:0] calib_cnt;
  logic        calib_divided;
  logic        calib_second;
  logic [3:0]  short_cnt_reg;
  logic [3:0]  short_mask;
  logic        short_tick;
  rtcw_cfg_t   wk_cfg;
  logic        wk_tick;
  logic [RTCW_WUT_W-1:0]   wk_load;
  logic [RTCW_WUT_W-1:0]   wk_cnt_reg;
  logic        wk_expire;

  // ==========================================================
  // axi4-lite handshakes
  assign aw_take      = s_axi_awvalid && s_axi_awready;
  assign w_take       = s_axi_wvalid && s_axi_wready;
  assign ar_take      = s_axi_arvalid && s_axi_arready;
  assign wr_fire      = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign aw_held_next = (aw_held_reg && !wr_fire) || aw_take;
  assign w_held_next  = (w_held_reg && !wr_fire) || w_take;
  assign bvalid_next  = wr_fire || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_next  = ar_take || (s_axi_rvalid && !s_axi_rready);

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      s_axi_awready <= !aw_held_next && !bvalid_next;
      s_axi_wready  <= !w_held_next && !bvalid_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RTCW_RESP_OKAY;
    end else begin
      s_axi_bvalid <= bvalid_next;
      if (wr_fire) begin
        s_axi_bresp <= rtcw_reg_hit(awaddr_reg) ? RTCW_RESP_OKAY : RTCW_RESP_SLVERR;
      end
    end
  end

  // read channel, data one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RTCW_RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_take) begin
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rtcw_reg_hit(s_axi_araddr) ? RTCW_RESP_OKAY : RTCW_RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // register read images
  always_comb begin
    ctrl_one_rd = 32'h0000_0000;
    ctrl_one_rd[RTCW_CTL1_WSEL_LSB +: 3] = wakeup_clock_select;
    ctrl_one_rd[RTCW_CTL1_CALIB_OUTPUT_SELECT_BIT]     = calib_output_select;
    ctrl_one_rd[RTCW_CTL1_DIV_LSB +: 3]  = source_clock_divider;
    ctrl_one_rd[RTCW_CTL1_COMPACT_BIT]   = compact_variant;
    ctrl_two_rd = 32'h0000_0000;
    ctrl_two_rd[RTCW_CTL2_WTE_BIT]       = wakeup_timer_enable;
    presc_rd = 32'h0000_0000;
    presc_rd[RTCW_PRE_ASYNC_LSB +: RTCW_ASYNC_W] = async_prescaler_value;
    presc_rd[RTCW_PRE_SYNC_LSB +: RTCW_SYNC_W]   = sync_prescaler_value;
    reload_rd = {16'h0000, wakeup_reload_value};
    status_rd = 32'h0000_0000;
    status_rd[RTCW_STS_WAF_BIT] = wakeup_write_allowed_flag;
    status_rd[RTCW_STS_WUF_BIT] = wakeup_flag_reg;
    count_rd = {15'h0000, wk_cnt_reg};
  end

  // read mux
  always_comb begin
    case (s_axi_araddr)
      RTCW_OFF_CTRL_ONE:  rd_value = ctrl_one_rd;
      RTCW_OFF_CTRL_TWO:  rd_value = ctrl_two_rd;
      RTCW_OFF_PRESCALER: rd_value = presc_rd;
      RTCW_OFF_RELOAD:    rd_value = reload_rd;
      RTCW_OFF_STATUS:    rd_value = status_rd;
      RTCW_OFF_COUNTER:   rd_value = count_rd;
      default:            rd_value = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // control registers
  always_ff @(posedge aclk) begin
    logic [31:0] m;
    m = 32'h0000_0000;
    if (!aresetn) begin
      wakeup_clock_select   <= 3'h0;
      calib_output_select   <= 1'b0;
      source_clock_divider  <= 3'h0;
      compact_variant       <= 1'b0;
      wakeup_timer_enable   <= 1'b0;
      async_prescaler_value <= RTCW_ASYNC_RST;
      sync_prescaler_value  <= RTCW_SYNC_RST;
      wakeup_reload_value   <= RTCW_RELOAD_RST;
    end else if (wr_fire) begin
      case (awaddr_reg)
        RTCW_OFF_CTRL_ONE: begin
          m = rtcw_merge(ctrl_one_rd, wdata_reg, wstrb_reg);
          if (wakeup_write_allowed_flag) begin
            wakeup_clock_select <= m[RTCW_CTL1_WSEL_LSB +: 3];
          end
          calib_output_select  <= m[RTCW_CTL1_CALIB_OUTPUT_SELECT_BIT];
          source_clock_divider <= m[RTCW_CTL1_DIV_LSB +: 3];
          compact_variant      <= m[RTCW_CTL1_COMPACT_BIT];
        end
        RTCW_OFF_CTRL_TWO: begin
          m = rtcw_merge(ctrl_two_rd, wdata_reg, wstrb_reg);
          wakeup_timer_enable <= m[RTCW_CTL2_WTE_BIT];
        end
        RTCW_OFF_PRESCALER: begin
          m = rtcw_merge(presc_rd, wdata_reg, wstrb_reg);
          // zero is not trapped, software keeps it legal
          async_prescaler_value <= m[RTCW_PRE_ASYNC_LSB +: RTCW_ASYNC_W];
          sync_prescaler_value  <= m[RTCW_PRE_SYNC_LSB +: RTCW_SYNC_W];
        end
        RTCW_OFF_RELOAD: begin
          m = rtcw_merge(reload_rd, wdata_reg, wstrb_reg);
          if (wakeup_write_allowed_flag) begin
            wakeup_reload_value <= m[15:0];
          end
        end
        default: begin
          m = 32'h0000_0000;
        end
      endcase
    end
  end

  // write-allowed follows disable after two kernel cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waf_pipe_reg <= '1;
    end else begin
      waf_pipe_reg <= {waf_pipe_reg[RTCW_WAF_DELAY-2:0], !wakeup_timer_enable};
    end
  end
  assign wakeup_write_allowed_flag = waf_pipe_reg[RTCW_WAF_DELAY-1] && !wakeup_timer_enable;

  // ==========================================================
  // prescaler chain
  assign src_mask = (source_clock_divider > RTCW_SRCDIV_MAX) ?
                    ~(RTCW_SRC_W'(0)) : ~(~(RTCW_SRC_W'(0)) << source_clock_divider);
  assign src_tick = ((src_cnt_reg & src_mask) == src_mask);

  // source clock divider, power of two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_cnt_reg <= '0;
    end else begin
      src_cnt_reg <= src_cnt_reg + RTCW_SRC_W'(1);
    end
  end

  // async prescaler, divide by value plus one
  rtcw_divider #(.W(RTCW_ASYNC_W)) u_async (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick_in   (src_tick),
    .limit     (async_prescaler_value),
    .count_reg (async_cnt),
    .tick_out  (async_tick)
  );

  // sync prescaler makes the second tick
  rtcw_divider #(.W(RTCW_SYNC_W)) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick_in   (async_tick),
    .limit     (sync_prescaler_value),
    .count_reg (sync_cnt),
    .tick_out  (calendar_second_tick)
  );

  // ==========================================================
  // calibration output
  // divider from low six prescaler bits
  rtcw_divider #(.W(RTCW_CALIB_W)) u_calib (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick_in   (src_tick),
    .limit     (async_prescaler_value[RTCW_CALIB_W-1:0]),
    .count_reg (calib_cnt),
    .tick_out  ()
  );

  // square wave spanning divider times prescaler
  assign calib_divided = (calib_cnt <= (async_prescaler_value[RTCW_CALIB_W-1:0] >> 1));
  assign calib_second  = (sync_cnt <= (sync_prescaler_value >> 1));

  // output pin selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      calib_output_pin <= 1'b0;
    end else if (!async_prescaler_value[RTCW_CAL_EN_BIT]) begin
      calib_output_pin <= 1'b0;
    end else if (!calib_output_select || compact_variant) begin
      calib_output_pin <= calib_divided;
    end else begin
      calib_output_pin <= calib_second;
    end
  end

  // ==========================================================
  // wakeup timer
  // configuration decode
  always_comb begin
    case (wakeup_clock_select)
      3'b000, 3'b001, 3'b010, 3'b011: wk_cfg = RTCW_CFG_SHORT;
      3'b100, 3'b101:                 wk_cfg = RTCW_CFG_MEDIUM;
      3'b110, 3'b111:                 wk_cfg = RTCW_CFG_LONG;
      default:                        wk_cfg = RTCW_CFG_SHORT;
    endcase
  end

  // short clock divides by 16, 8, 4 or 2
  assign short_mask = RTCW_SHORT_MASK >> wakeup_clock_select[1:0];
  assign short_tick = src_tick && ((short_cnt_reg & short_mask) == short_mask);

  // short-period divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_cnt_reg <= 4'h0;
    end else if (src_tick) begin
      short_cnt_reg <= short_cnt_reg + 4'h1;
    end
  end

  // medium and long count on second tick
  assign wk_tick = (wk_cfg == RTCW_CFG_SHORT) ? short_tick : calendar_second_tick;
  assign wk_load = (wk_cfg == RTCW_CFG_LONG) ?
                   ({1'b0, wakeup_reload_value} + RTCW_LONG_ADD) :
                   {1'b0, wakeup_reload_value};
  assign wk_expire = wakeup_timer_enable && wk_tick && (wk_cnt_reg == '0);

  // down counter, leaves zero at 011b to software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wk_cnt_reg <= {1'b0, RTCW_RELOAD_RST};
    end else if (!wakeup_timer_enable) begin
      wk_cnt_reg <= wk_load;
    // reload plus one ticks per period, reload plus 65537 in the long configuration
    end else if (wk_expire) begin
      wk_cnt_reg <= wk_load;
    end else if (wk_tick) begin
      wk_cnt_reg <= wk_cnt_reg - RTCW_WUT_W'(1);
    end
  end

  // sticky flag, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_flag_reg <= 1'b0;
      wakeup_event    <= 1'b0;
    end else begin
      wakeup_event <= wk_expire;
      if (wk_expire) begin
        wakeup_flag_reg <= 1'b1;
      end else if (wr_fire && (awaddr_reg == RTCW_OFF_STATUS) && wstrb_reg[0] &&
                   wdata_reg[RTCW_STS_WUF_BIT]) begin
        wakeup_flag_reg <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/rtcw_pkg.sv
package rtcw_pkg;

  // ==========================================================
  // bus geometry
  localparam int          RTCW_ADDR_W     = 8;
  localparam logic [1:0]  RTCW_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RTCW_RESP_SLVERR = 2'h2;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  RTCW_OFF_CTRL_ONE  = 8'h00;
  localparam logic [7:0]  RTCW_OFF_CTRL_TWO  = 8'h04;
  localparam logic [7:0]  RTCW_OFF_PRESCALER = 8'h08;
  localparam logic [7:0]  RTCW_OFF_RELOAD    = 8'h0c;
  localparam logic [7:0]  RTCW_OFF_STATUS    = 8'h10;
  localparam logic [7:0]  RTCW_OFF_COUNTER   = 8'h14;

  // ==========================================================
  // field positions
  localparam int RTCW_CTL1_WSEL_LSB   = 0;   // wakeup_clock_select [2:0]
  localparam int RTCW_CTL1_CALIB_OUTPUT_SELECT_BIT  = 3;   // calib_output_select
  localparam int RTCW_CTL1_DIV_LSB    = 4;   // source_clock_divider [6:4]
  localparam int RTCW_CTL1_COMPACT_BIT = 7;  // smaller device variant
  localparam int RTCW_CTL2_WTE_BIT    = 0;   // wakeup_timer_enable
  localparam int RTCW_PRE_ASYNC_LSB   = 0;   // async_prescaler_value [6:0]
  localparam int RTCW_PRE_SYNC_LSB    = 16;  // sync_prescaler_value [30:16]
  localparam int RTCW_STS_WAF_BIT     = 0;   // wakeup_write_allowed_flag
  localparam int RTCW_STS_WUF_BIT     = 1;   // wakeup flag, write one to clear

  // ==========================================================
  // field widths and reset values
  localparam int          RTCW_ASYNC_W   = 7;
  localparam int          RTCW_SYNC_W    = 15;
  localparam int          RTCW_CALIB_W   = 6;
  localparam int          RTCW_SRC_W     = 6;
  localparam int          RTCW_WUT_W     = 17;
  localparam logic [6:0]  RTCW_ASYNC_RST = 7'h7f;
  localparam logic [14:0] RTCW_SYNC_RST  = 15'h00ff;
  localparam logic [15:0] RTCW_RELOAD_RST = 16'hffff;
  localparam logic [2:0]  RTCW_SRCDIV_MAX = 3'h6;     // 111b acts as 110b (div64)
  localparam logic [16:0] RTCW_LONG_ADD  = 17'h10000;
  localparam logic [3:0]  RTCW_SHORT_MASK = 4'hf;     // div16 at select 000b
  localparam int          RTCW_CAL_EN_BIT = 5;        // prescaler bit gating calib output
  localparam int          RTCW_WAF_DELAY = 2;         // kernel cycles to write-allowed

  // ==========================================================
  // wakeup counting configurations
  typedef enum logic [1:0] {
    RTCW_CFG_SHORT  = 2'b00,
    RTCW_CFG_MEDIUM = 2'b01,
    RTCW_CFG_LONG   = 2'b10
  } rtcw_cfg_t;

endpackage

// file: rtl/rtcw_divider.sv
`timescale 1ns/100ps
// counts enabled ticks from zero up to limit, pulses on wrap
module rtcw_divider #(
  parameter int W = 8
) (
  input  wire logic         aclk,       // kernel clock
  input  wire logic         aresetn,    // sync reset, active low
  input  wire logic         tick_in,    // count enable pulse
  input  wire logic [W-1:0] limit,      // divide by limit + 1
  output logic      [W-1:0] count_reg,  // current count
  output logic              tick_out    // wrap pulse, same cycle as tick_in
);

  // wrap detect
  assign tick_out = tick_in && (count_reg >= limit);

  // counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else if (tick_out) begin
      count_reg <= '0;
    end else if (tick_in) begin
      count_reg <= count_reg + W'(1);
    end
  end

endmodule

// file: tb/rtcw_checker.sv
`timescale 1ns/100ps
// ==========================================================
// bus handshake and answer checks on the top ports
module rtcw_checker
  import rtcw_pkg::*;
(
  input wire logic        aclk,             // kernel clock
  input wire logic        aresetn,          // sync reset, active low
  input wire logic        s_axi_awvalid,    // write address valid
  input wire logic        s_axi_awready,    // write address ready
  input wire logic        s_axi_wvalid,     // write data valid
  input wire logic        s_axi_wready,     // write data ready
  input wire logic [1:0]  s_axi_bresp,      // write response
  input wire logic        s_axi_bvalid,     // write response valid
  input wire logic        s_axi_bready,     // write response ready
  input wire logic [7:0]  s_axi_araddr,     // read address
  input wire logic        s_axi_arvalid,    // read address valid
  input wire logic        s_axi_arready,    // read address ready
  input wire logic [31:0] s_axi_rdata,      // read data
  input wire logic [1:0]  s_axi_rresp,      // read response
  input wire logic        s_axi_rvalid,     // read data valid
  input wire logic        s_axi_rready,     // read data ready
  input wire logic        calib_output_pin, // calibration output
  input wire logic        wakeup_event      // expiry pulse
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // answers stand until taken
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  // write answer two edges after a joint take, read answer one edge after
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // ready falls after a take
  a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
    else $error("write address ready not withdrawn");
  a_ar_drop: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read address ready not withdrawn");
  // reads above the counter offset refused with zero data
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > RTCW_OFF_COUNTER |=> s_axi_rresp == RTCW_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_reset_quiet: assert property ($rose(aresetn) |->
    !s_axi_awready && !s_axi_arready && !s_axi_bvalid) else $error("outputs active out of reset");

  c_wake: cover property (wakeup_event);
  c_calib: cover property ($rose(calib_output_pin));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == RTCW_RESP_SLVERR);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind rtcw_top rtcw_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .calib_output_pin, .wakeup_event);

// file: tb/rtcw_top_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
// ==========================================================
// register driven bench for the calib output and wakeup timer
module rtcw_top_test
  import rtcw_pkg::*;
;
  typedef struct {
    logic [7:0]  c1;
    logic [31:0] pre;
    logic [15:0] rl;
    int          k;   // 0 wakeup period, 1 calib period, 2 counter read
    logic [31:0] e;
  } rtcw_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bry = 1'b0;
  logic        arv = 1'b0;
  logic        rry = 1'b0;
  logic [7:0]  awa = 8'h00;
  logic [7:0]  ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awr, wrdy, bv, arr, rv, cal, wev;
  logic [1:0]  br, rr;
  logic [31:0] rd;
  int          bad_count = 0;
  int          num_checks = 0;
  logic [7:0]  ro[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0] re[6] = '{32'h0, 32'h0, 32'h00ff007f, 32'hffff, 32'h1, 32'hffff};
  rtcw_row_t   rows[13] = '{
    '{8'h00, 32'h00010001, 16'h3, 0, 32'd64},    // div16, reload 3
    // select 011b never paired with reload zero
    '{8'h03, 32'h00010001, 16'h1, 0, 32'd4},     // div2, reload 1
    '{8'h11, 32'h00010001, 16'h2, 0, 32'd48},    // source div2, div8
    '{8'h02, 32'h00010001, 16'h5, 0, 32'd24},    // div4, reload 5
    '{8'h04, 32'h00010001, 16'h0, 0, 32'd4},     // medium, reload 0
    '{8'h15, 32'h00020001, 16'h1, 0, 32'd24},    // medium, second tick 12
    '{8'h06, 32'h00010001, 16'h5, 2, 32'h10005}, // long load
    '{8'h07, 32'h00010001, 16'h0, 2, 32'h10000}, // long load, 111b
    '{8'h00, 32'h00010020, 16'h0, 1, 32'd33},    // fastest calib
    '{8'h70, 32'h0001003f, 16'h0, 1, 32'd4096},  // slowest calib
    '{8'h00, 32'h0001001f, 16'h0, 1, 32'd0},     // gate bit clear
    '{8'h08, 32'h00010021, 16'h0, 1, 32'd68},    // one-second tick out
    // compact variant keeps async prescaler nonzero
    '{8'h88, 32'h00010021, 16'h0, 1, 32'd34}};   // compact variant

  rtcw_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .calib_output_pin(cal),
    .wakeup_event(wev));

  // 250 MHz kernel clock
  always #2 aclk = ~aclk;

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 500);
    if (n >= 500) bad_count++;
    r = br;
    bry <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 500);
    if (n >= 500) bad_count++;
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask

  // disable, wait for write access, then program
  task automatic cfg(input logic [7:0] c1, input logic [31:0] pre, input logic [15:0] rl);
    logic [31:0] d;
    logic [1:0]  r;
    wr(RTCW_OFF_CTRL_TWO, 32'h0, r);
    do rdr(RTCW_OFF_STATUS, d, r); while (d[0] !== 1'b1);
    wr(RTCW_OFF_PRESCALER, pre, r);
    wr(RTCW_OFF_CTRL_ONE, {24'h0, c1}, r);
    wr(RTCW_OFF_RELOAD, {16'h0, rl}, r);
  endtask

  // cycles between two rising edges of the pin or the pulse
  task automatic per(input bit c, input int lim, output int cyc);
    int n, k;
    logic p, s;
    n = 0;
    k = 0;
    p = 1'b1;
    while (k < 2 && n < lim) begin
      @(posedge aclk);
      s = c ? cal : wev;
      n++;
      if (s === 1'b1 && p !== 1'b1) begin
        k++;
        cyc = n;
        n = 0;
      end
      p = s;
    end
    if (k < 2) cyc = 0;
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d, g;
    logic [1:0]  r;
    int          cyc, n;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ro[i]) begin
      rdr(ro[i], d, r);
      `CHK("reset value", re[i], d)
    end
    foreach (rows[i]) begin
      cfg(rows[i].c1, rows[i].pre, rows[i].rl);
      if (rows[i].k == 0) wr(RTCW_OFF_CTRL_TWO, 32'h1, r);
      if (rows[i].k == 2) rdr(RTCW_OFF_COUNTER, g, r);
      else begin
        per(rows[i].k == 1, 5000, cyc);
        g = cyc;
      end
      `CHK("row result", rows[i].e, g)
    end
    rdr(8'h18, d, r);
    `CHK("unmapped rresp", RTCW_RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0, d)
    wr(8'h1c, 32'h5, r);
    `CHK("unmapped bresp", RTCW_RESP_SLVERR, r)
    // flag set while running, access locked
    cfg(8'h00, 32'h00010001, 16'h3);
    wr(RTCW_OFF_CTRL_TWO, 32'h1, r);
    repeat (100) @(posedge aclk);
    rdr(RTCW_OFF_STATUS, d, r);
    `CHK("status running", 32'h2, d)
    wr(RTCW_OFF_RELOAD, 32'h9, r);
    rdr(RTCW_OFF_RELOAD, d, r);
    `CHK("locked reload", 32'h3, d)
    repeat (30) @(posedge aclk);
    wr(RTCW_OFF_CTRL_TWO, 32'h0, r);
    wr(RTCW_OFF_STATUS, 32'h2, r);
    rdr(RTCW_OFF_STATUS, d, r);
    `CHK("status cleared", 32'h1, d)
    // restart counts a full period from the reload value
    wr(RTCW_OFF_CTRL_TWO, 32'h1, r);
    n = 0;
    while (wev !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    `CHK("restart delay", 1'b1, (n >= 45 && n <= 70))
    print_verdict;
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    print_verdict;
  end
endmodule
